// ==== inc/dasp_cfg.svh ====
// constants of the dual converter serial and power control block
// Overview of operation
// [RULE1] select fall: hold, sample, start, drive outputs
// [RULE2] host keeps select low ten falls
// [RULE3] rise after 10th, before 14th: abort, stay powered
// [RULE4] fourteen clocks give one full result
// [RULE5] after 14 clocks line stays driven
// [RULE6] two trailing zeros after the result
// [RULE7] longer frame swaps in other converter result
// [RULE8] identification bit precedes every result
// [RULE9] line releases at 32nd fall or rise
// [RULE10] host waits quiet gap before next frame
// [RULE11] rise between 2nd and 10th: partial down
// [RULE12] rise before 2nd fall is a glitch
// [RULE13] dummy conversion wakes; next conversion valid
// [RULE14] partial down, early rise: stays partial down
// [RULE15] partial down, 2nd to 10th rise: full down
// [RULE16] power-down frames need no remaining clocks
// [RULE17] full wake needs dummy frame and wait
// [RULE18] after 13 falls, track on next rise
// [RULE19] two leading zeros, twelve bits, msb first; code sends one zero, then the id bit
// [RULE20] slow clock lets host sample rising edges
// [RULE21] select fall latches config for next conversion
// [RULE22] coding straight binary or twos complement
// [RULE23] count falls per frame, track power state
`ifndef DASP_CFG_SVH
`define DASP_CFG_SVH

`define DASP_CLK_NS 40
`define DASP_PART_PWRUP_NS 1000
`define DASP_PART_PWRUP_CYC ((`DASP_PART_PWRUP_NS + `DASP_CLK_NS - 1) / `DASP_CLK_NS)

`define DASP_CNT_GLITCH 6'h02
`define DASP_CNT_POWERED 6'h0A
`define DASP_CNT_TRACK 6'h0D
`define DASP_CNT_FRAME 6'h0E
`define DASP_SLOT_FIRST_DATA 6'h02
`define DASP_SLOT_LAST_DATA 6'h0D
`define DASP_SLOT_ID 6'h01
`define DASP_SLOT_SECOND 6'h10
`define DASP_CNT_DUAL 6'h20

`define DASP_TWOS_FLIP 12'h800

`define DASP_ADDR_CTRL 8'h00
`define DASP_ADDR_TEST_FIRST 8'h04
`define DASP_ADDR_TEST_SECOND 8'h08
`define DASP_ADDR_STATUS 8'h0C
`define DASP_ADDR_LAST_FIRST 8'h10
`define DASP_ADDR_LAST_SECOND 8'h14

`define DASP_CTRL_TEST_BIT 0
`define DASP_RST_CTRL 1'h0
`define DASP_RST_TEST 12'h000

`endif

// ==== inc/dasp_pkg.sv ====
// types shared by the dual converter serial and power control block
package dasp_pkg;

    typedef enum logic [1:0] {
        PWR_NORMAL,
        PWR_PARTIAL,
        PWR_FULL
    } dasp_pwr_e;

    typedef struct packed {
        logic single_ended;
        logic [2:0] channel;
        logic wide_range;
    } dasp_cfg_s;

    typedef struct packed {
        logic start_n;
        logic shift_clk;
        dasp_cfg_s cfg;
    } dasp_pins_s;

endpackage : dasp_pkg

// ==== verilog/dasp_sync.sv ====
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module dasp_sync #(
    parameter int W = 7,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // per bit: a change is accepted only once stages two and three agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= RST_VAL;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    q[i] <= s3_q[i];
                end
            end
        end
    end
endmodule : dasp_sync

// ==== verilog/dasp_top.sv ====
// dual converter serial readout and power-mode control
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/100ps
`include "dasp_cfg.svh"
module dasp_top import dasp_pkg::*; #(
    parameter logic [19:0] FULL_PWRUP_CYC = 20'h009C4
) (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic CONV_START_N,
    input wire logic SERIAL_SHIFT_CLOCK,
    input wire logic INPUT_CONFIG_SELECT,
    input wire logic [2:0] CHANNEL_SELECT,
    input wire logic RANGE_SELECT,
    input wire logic [11:0] CONV_RESULT_FIRST,
    input wire logic [11:0] CONV_RESULT_SECOND,
    input wire logic [7:0] BUS_ADDR,
    input wire logic [31:0] BUS_WDATA,
    input wire logic BUS_WR,
    input wire logic BUS_RD,
    output logic [31:0] BUS_RDATA,
    output logic SAMPLE_OUT_FIRST,
    output logic SAMPLE_OUT_FIRST_OE,
    output logic SAMPLE_OUT_SECOND,
    output logic SAMPLE_OUT_SECOND_OE,
    output logic TRACK_HOLD,
    output logic SAMPLE_STROBE,
    output dasp_cfg_s MUX_CFG,
    output dasp_pwr_e POWER_MODE,
    output logic ANALOG_POWER_ON,
    output logic FULLY_POWERED
);
    dasp_pins_s pins_raw;
    dasp_pins_s pins_f;
    logic cs_p_q;
    logic sclk_p_q;
    logic cs_fall;
    logic cs_rise;
    logic sclk_fall;
    logic sclk_rise;
    logic in_frame_q;
    logic [5:0] cnt_q;
    logic [5:0] slot_d;
    logic [11:0] res_first_q;
    logic [11:0] res_second_q;
    logic twos_q;
    logic frame_valid_q;
    dasp_pwr_e pwr_q;
    logic analog_on;
    logic wake_full_q;
    logic [19:0] up_cnt_q;
    logic [19:0] up_target;
    logic ctrl_test_q;
    logic [11:0] test_first_q;
    logic [11:0] test_second_q;
    logic [11:0] src_first;
    logic [11:0] src_second;

    // converter first reports id 0, converter second id 1
    function automatic logic stream_bit(
        input logic [5:0] slot,
        input logic [11:0] own,
        input logic [11:0] other,
        input logic own_id
    );
        logic [5:0] pos;
        logic [11:0] val;
        logic id;
        pos = slot;
        val = own;
        id = own_id;
        if (slot >= `DASP_SLOT_SECOND) begin
            pos = slot - `DASP_SLOT_SECOND;
            val = other;
            id = ~own_id;
        end
        stream_bit = 1'b0;
        if (pos == `DASP_SLOT_ID) begin
            stream_bit = id;
        end else if (pos >= `DASP_SLOT_FIRST_DATA && pos <= `DASP_SLOT_LAST_DATA) begin
            stream_bit = val[4'(`DASP_SLOT_LAST_DATA - pos)];
        end
    endfunction : stream_bit

    // analog core delivers offset binary; flip msb for twos complement
    function automatic logic is_twos(input dasp_cfg_s c);
        is_twos = c.wide_range | (~c.single_ended & ~c.channel[0]);
    endfunction : is_twos

    function automatic logic [11:0] code_of(input logic [11:0] raw, input dasp_cfg_s c);
        code_of = is_twos(c) ? (raw ^ `DASP_TWOS_FLIP) : raw;
    endfunction : code_of

    assign pins_raw.start_n = CONV_START_N;
    assign pins_raw.shift_clk = SERIAL_SHIFT_CLOCK;
    assign pins_raw.cfg.single_ended = INPUT_CONFIG_SELECT;
    assign pins_raw.cfg.channel = CHANNEL_SELECT;
    assign pins_raw.cfg.wide_range = RANGE_SELECT;

    dasp_sync #(
        .W(7),
        .RST_VAL(7'h40)
    ) u_sync (
        .clk(CLOCK),
        .rst(RESET),
        .d(pins_raw),
        .q(pins_f)
    );

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            cs_p_q <= 1'b1;
            sclk_p_q <= 1'b0;
        end else begin
            cs_p_q <= pins_f.start_n;
            sclk_p_q <= pins_f.shift_clk;
        end
    end

    assign cs_fall = cs_p_q & ~pins_f.start_n;
    assign cs_rise = ~cs_p_q & pins_f.start_n;
    assign sclk_fall = sclk_p_q & ~pins_f.shift_clk;
    assign sclk_rise = ~sclk_p_q & pins_f.shift_clk;
    assign slot_d = cnt_q + 6'h01;

    // frame tracking and falling-edge count, saturating at the dual-read end
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            in_frame_q <= 1'b0;
            cnt_q <= 6'h00;
        end else if (cs_fall) begin
            in_frame_q <= 1'b1;
            cnt_q <= 6'h00; // see [RULE23]
        end else if (cs_rise) begin
            in_frame_q <= 1'b0;
        end else if (sclk_fall && in_frame_q && cnt_q < `DASP_CNT_DUAL) begin
            cnt_q <= slot_d; // see [RULE23]
        end
    end

    assign src_first = ctrl_test_q ? test_first_q : CONV_RESULT_FIRST;
    assign src_second = ctrl_test_q ? test_second_q : CONV_RESULT_SECOND;

    // results are frozen at the sampling instant; the config latched now
    // only steers the next conversion
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            res_first_q <= 12'h000;
            res_second_q <= 12'h000;
            twos_q <= 1'b0;
            MUX_CFG <= '0;
            frame_valid_q <= 1'b0;
        end else if (cs_fall) begin
            res_first_q <= code_of(src_first, MUX_CFG); // see [RULE22]
            res_second_q <= code_of(src_second, MUX_CFG); // see [RULE22]
            twos_q <= is_twos(MUX_CFG);
            MUX_CFG <= pins_f.cfg; // see [RULE21]
            frame_valid_q <= (pwr_q == PWR_NORMAL) && FULLY_POWERED; // see [RULE13]
        end
    end

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            SAMPLE_STROBE <= 1'b0;
        end else begin
            SAMPLE_STROBE <= cs_fall; // see [RULE1]
        end
    end

    // select rise takes precedence over a shift-clock fall seen in the same cycle
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            SAMPLE_OUT_FIRST <= 1'b0;
            SAMPLE_OUT_SECOND <= 1'b0;
            SAMPLE_OUT_FIRST_OE <= 1'b0;
            SAMPLE_OUT_SECOND_OE <= 1'b0;
        end else if (cs_fall) begin
            SAMPLE_OUT_FIRST <= 1'b0; // see [RULE19]
            SAMPLE_OUT_SECOND <= 1'b0;
            SAMPLE_OUT_FIRST_OE <= 1'b1; // see [RULE1]
            SAMPLE_OUT_SECOND_OE <= 1'b1;
        end else if (cs_rise) begin
            SAMPLE_OUT_FIRST <= 1'b0;
            SAMPLE_OUT_SECOND <= 1'b0;
            SAMPLE_OUT_FIRST_OE <= 1'b0; // see [RULE3] [RULE11]
            SAMPLE_OUT_SECOND_OE <= 1'b0;
        end else if (sclk_fall && in_frame_q && cnt_q < `DASP_CNT_DUAL) begin
            if (slot_d == `DASP_CNT_DUAL) begin
                SAMPLE_OUT_FIRST <= 1'b0;
                SAMPLE_OUT_SECOND <= 1'b0;
                SAMPLE_OUT_FIRST_OE <= 1'b0; // see [RULE9]
                SAMPLE_OUT_SECOND_OE <= 1'b0;
            end else begin
                // see [RULE4] [RULE5] [RULE6] [RULE7] [RULE8] [RULE19]
                SAMPLE_OUT_FIRST <= stream_bit(slot_d, res_first_q, res_second_q, 1'b0);
                SAMPLE_OUT_SECOND <= stream_bit(slot_d, res_second_q, res_first_q, 1'b1);
            end
        end
    end

    // track-and-hold: hold from sampling until the rise after the 13th fall
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            TRACK_HOLD <= 1'b0;
        end else if (cs_fall) begin
            TRACK_HOLD <= 1'b1; // see [RULE1]
        end else if (cs_rise) begin
            TRACK_HOLD <= 1'b0;
        end else if (sclk_rise && cnt_q >= `DASP_CNT_TRACK) begin
            TRACK_HOLD <= 1'b0; // see [RULE18]
        end
    end

    // power mode; frames that end early need no further clocks
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            pwr_q <= PWR_NORMAL;
        end else if (cs_rise && in_frame_q) begin
            if (cnt_q >= `DASP_CNT_GLITCH && cnt_q < `DASP_CNT_POWERED) begin
                case (pwr_q)
                    PWR_NORMAL: pwr_q <= PWR_PARTIAL; // see [RULE11] [RULE16]
                    PWR_PARTIAL: pwr_q <= PWR_FULL; // see [RULE15]
                    PWR_FULL: pwr_q <= PWR_FULL;
                    default: pwr_q <= PWR_FULL;
                endcase
            end
            // earlier rise leaves the mode as it was: see [RULE12] [RULE14]
        end else if (sclk_fall && in_frame_q && slot_d == `DASP_CNT_POWERED) begin
            pwr_q <= PWR_NORMAL; // see [RULE13] [RULE3]
        end
    end

    assign POWER_MODE = pwr_q;

    // analog supply follows the mode, and is also up while a frame is low
    assign analog_on = (pwr_q == PWR_NORMAL) || (in_frame_q && !cs_rise);
    assign up_target = wake_full_q ? FULL_PWRUP_CYC : 20'(`DASP_PART_PWRUP_CYC);

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            wake_full_q <= 1'b0;
        end else if (pwr_q == PWR_FULL) begin
            wake_full_q <= 1'b1;
        end else if (FULLY_POWERED) begin
            wake_full_q <= 1'b0;
        end
    end

    // reset leaves the converter treated as already powered up
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            up_cnt_q <= 20'h00000;
            ANALOG_POWER_ON <= 1'b1;
            FULLY_POWERED <= 1'b1;
        end else begin
            ANALOG_POWER_ON <= analog_on;
            if (!analog_on) begin
                up_cnt_q <= 20'h00000;
                FULLY_POWERED <= 1'b0; // see [RULE14]
            end else if (!FULLY_POWERED) begin
                if (up_cnt_q >= up_target) begin
                    FULLY_POWERED <= 1'b1; // see [RULE13] [RULE17]
                end else begin
                    up_cnt_q <= up_cnt_q + 20'h00001;
                end
            end
        end
    end

    // register port: writes take effect on the strobe edge
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            ctrl_test_q <= `DASP_RST_CTRL;
            test_first_q <= `DASP_RST_TEST;
            test_second_q <= `DASP_RST_TEST;
        end else if (BUS_WR) begin
            case (BUS_ADDR)
                `DASP_ADDR_CTRL: ctrl_test_q <= BUS_WDATA[`DASP_CTRL_TEST_BIT];
                `DASP_ADDR_TEST_FIRST: test_first_q <= BUS_WDATA[11:0];
                `DASP_ADDR_TEST_SECOND: test_second_q <= BUS_WDATA[11:0];
                default: ;
            endcase
        end
    end

    // read data stand for the single cycle after the read strobe
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            BUS_RDATA <= 32'h00000000;
        end else if (BUS_RD) begin
            case (BUS_ADDR)
                `DASP_ADDR_CTRL: BUS_RDATA <= {31'h0, ctrl_test_q};
                `DASP_ADDR_TEST_FIRST: BUS_RDATA <= {20'h0, test_first_q};
                `DASP_ADDR_TEST_SECOND: BUS_RDATA <= {20'h0, test_second_q};
                `DASP_ADDR_STATUS: BUS_RDATA <= {15'h0, MUX_CFG, twos_q, frame_valid_q,
                                                 in_frame_q, cnt_q, FULLY_POWERED, pwr_q};
                `DASP_ADDR_LAST_FIRST: BUS_RDATA <= {20'h0, res_first_q};
                `DASP_ADDR_LAST_SECOND: BUS_RDATA <= {20'h0, res_second_q};
                default: BUS_RDATA <= 32'h00000000;
            endcase
        end else begin
            BUS_RDATA <= 32'h00000000;
        end
    end

    property p_fall_drives;
        @(posedge CLOCK) disable iff (RESET)
        cs_fall |=> SAMPLE_OUT_FIRST_OE && SAMPLE_OUT_SECOND_OE && TRACK_HOLD && !SAMPLE_OUT_FIRST;
    endproperty
    a_fall_drives: assert property (p_fall_drives) // see [RULE1]
        else $error("select fall did not drive both lines");

    property p_rise_release;
        @(posedge CLOCK) disable iff (RESET)
        cs_rise |=> !SAMPLE_OUT_FIRST_OE && !SAMPLE_OUT_SECOND_OE;
    endproperty
    a_rise_release: assert property (p_rise_release) // see [RULE3]
        else $error("select rise did not release the lines");

    property p_stay_driven;
        @(posedge CLOCK) disable iff (RESET)
        SAMPLE_OUT_FIRST_OE && !cs_rise && !(sclk_fall && cnt_q == 6'h1F) |=> SAMPLE_OUT_FIRST_OE;
    endproperty
    a_stay_driven: assert property (p_stay_driven) // see [RULE5]
        else $error("line released while select still low");

    property p_trailing;
        @(posedge CLOCK) disable iff (RESET)
        sclk_fall && in_frame_q && !cs_rise && (cnt_q == 6'h0D || cnt_q == 6'h0E)
            |=> !SAMPLE_OUT_FIRST && !SAMPLE_OUT_SECOND;
    endproperty
    a_trailing: assert property (p_trailing) // see [RULE6]
        else $error("trailing bit not zero");

    property p_id_swap;
        @(posedge CLOCK) disable iff (RESET)
        sclk_fall && in_frame_q && !cs_rise && cnt_q == 6'h10
            |=> SAMPLE_OUT_FIRST && !SAMPLE_OUT_SECOND;
    endproperty
    a_id_swap: assert property (p_id_swap) // see [RULE7]
        else $error("second-half id bit wrong");

    property p_msb;
        @(posedge CLOCK) disable iff (RESET)
        sclk_fall && in_frame_q && !cs_rise && cnt_q == 6'h01
            |=> SAMPLE_OUT_FIRST == res_first_q[11] && SAMPLE_OUT_SECOND == res_second_q[11];
    endproperty
    a_msb: assert property (p_msb) // see [RULE19]
        else $error("msb not on second fall");

    property p_dual_end;
        @(posedge CLOCK) disable iff (RESET)
        sclk_fall && in_frame_q && !cs_rise && cnt_q == 6'h1F
            |=> !SAMPLE_OUT_FIRST_OE ##1 !SAMPLE_OUT_FIRST_OE || cs_fall;
    endproperty
    a_dual_end: assert property (p_dual_end) // see [RULE9]
        else $error("line not released at 32nd fall");

    property p_partial;
        @(posedge CLOCK) disable iff (RESET)
        cs_rise && in_frame_q && pwr_q == PWR_NORMAL && cnt_q >= 6'h02 && cnt_q <= 6'h09
            |=> pwr_q == PWR_PARTIAL;
    endproperty
    a_partial: assert property (p_partial) // see [RULE11]
        else $error("partial power-down not entered");

    property p_glitch;
        @(posedge CLOCK) disable iff (RESET)
        cs_rise && cnt_q < 6'h02 |=> pwr_q == $past(pwr_q);
    endproperty
    a_glitch: assert property (p_glitch) // see [RULE12]
        else $error("early rise changed the power mode");

    property p_full;
        @(posedge CLOCK) disable iff (RESET)
        cs_rise && in_frame_q && pwr_q == PWR_PARTIAL && cnt_q >= 6'h02 && cnt_q <= 6'h09
            |=> pwr_q == PWR_FULL;
    endproperty
    a_full: assert property (p_full) // see [RULE15]
        else $error("full power-down not entered");

    property p_track;
        @(posedge CLOCK) disable iff (RESET)
        sclk_rise && !cs_fall && cnt_q >= 6'h0D |=> !TRACK_HOLD;
    endproperty
    a_track: assert property (p_track) // see [RULE18]
        else $error("track not resumed after 13th fall");

    property p_cfg_latch;
        @(posedge CLOCK) disable iff (RESET)
        cs_fall |=> MUX_CFG == $past(pins_f.cfg) && twos_q == is_twos($past(MUX_CFG));
    endproperty
    a_cfg_latch: assert property (p_cfg_latch) // see [RULE21]
        else $error("config not latched at select fall");

    c_power_partial: cover property (@(posedge CLOCK) disable iff (RESET)
        pwr_q == PWR_NORMAL ##1 pwr_q == PWR_PARTIAL);
    c_power_full: cover property (@(posedge CLOCK) disable iff (RESET)
        pwr_q == PWR_PARTIAL ##1 pwr_q == PWR_FULL);
    c_dual_read: cover property (@(posedge CLOCK) disable iff (RESET)
        sclk_fall && in_frame_q && cnt_q == 6'h1F);
    c_wake: cover property (@(posedge CLOCK) disable iff (RESET)
        !FULLY_POWERED ##1 FULLY_POWERED);
endmodule : dasp_top

// ==== tb/dasp_host_model.sv ====
// host serial port model: drives select and serial clock, samples both lines
`timescale 1ns/100ps
module dasp_host_model (
    input wire logic clk,
    output logic start_n,
    output logic sclk,
    input wire logic d_a,
    input wire logic oe_a,
    input wire logic d_b,
    input wire logic oe_b,
    input wire logic hold
);
    logic [32:0] da, db, ea, eb, th;
    logic line_a;
    logic line_b;
    logic rise_smp = 1'b0;
    int half = 4;
    int quiet = 8;
    // a released line floats: show the inverse so a late sample cannot pass
    assign line_a = oe_a ? d_a : ~d_a;
    assign line_b = oe_b ? d_b : ~d_b;
    initial begin
        start_n = 1'b1;
        sclk = 1'b0;
    end
    task automatic grab(input int k);
        {da[k], db[k], ea[k], eb[k], th[k]} = {line_a, line_b, oe_a, oe_b, hold};
    endtask : grab
    // sampled just before each fall, or before each rise when the clock is slow
    task automatic frame(input int n);
        start_n <= 1'b0;
        for (int k = 0; k < n; k++) begin
            repeat (half) @(posedge clk);
            if (rise_smp) grab(k);
            sclk <= 1'b1;
            repeat (half) @(posedge clk);
            if (!rise_smp) grab(k);
            sclk <= 1'b0;
        end
        repeat (2 * half) @(posedge clk);
        grab(n);
        start_n <= 1'b1;
        repeat (quiet) @(posedge clk);
    endtask : frame
endmodule : dasp_host_model

// ==== tb/dasp_top_tb_top.sv ====
// self-checking bench: serial readout, power modes and register port
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module dasp_top_tb_top import dasp_pkg::*; ();
    logic clock, reset, bus_wr, bus_rd, start_n, sclk, d_a, oe_a, d_b, oe_b, hold;
    logic apwr, fpwr;
    logic [7:0] bus_addr;
    logic [31:0] bus_wdata, bus_rdata, rd;
    logic [11:0] res_a, res_b;
    dasp_cfg_s pins, cur, mux_cfg;
    dasp_pwr_e pmode;
    int error_cnt, cmp_count;
    logic strb;
    int strobes;

    always @(posedge clock) if (strb) strobes <= strobes + 1;

    dasp_top #(.FULL_PWRUP_CYC(20'h00014)) i_dut (
        .CLOCK(clock),
        .RESET(reset),
        .CONV_START_N(start_n),
        .SERIAL_SHIFT_CLOCK(sclk),
        .INPUT_CONFIG_SELECT(pins.single_ended),
        .CHANNEL_SELECT(pins.channel),
        .RANGE_SELECT(pins.wide_range),
        .CONV_RESULT_FIRST(res_a),
        .CONV_RESULT_SECOND(res_b),
        .BUS_ADDR(bus_addr),
        .BUS_WDATA(bus_wdata),
        .BUS_WR(bus_wr),
        .BUS_RD(bus_rd),
        .BUS_RDATA(bus_rdata),
        .SAMPLE_OUT_FIRST(d_a),
        .SAMPLE_OUT_FIRST_OE(oe_a),
        .SAMPLE_OUT_SECOND(d_b),
        .SAMPLE_OUT_SECOND_OE(oe_b),
        .TRACK_HOLD(hold),
        .SAMPLE_STROBE(strb),
        .MUX_CFG(mux_cfg),
        .POWER_MODE(pmode),
        .ANALOG_POWER_ON(apwr),
        .FULLY_POWERED(fpwr)
    );
    dasp_host_model i_host (.clk(clock), .start_n(start_n), .sclk(sclk), .d_a(d_a),
        .oe_a(oe_a), .d_b(d_b), .oe_b(oe_b), .hold(hold));

    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test

    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clock);
        bus_wr <= 1'b0;
    endtask : bus_write

    task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clock);
        bus_rd <= 1'b0;
        @(negedge clock);
        d = bus_rdata;
    endtask : bus_read

    function automatic logic slot_bit(int s, logic [11:0] own, logic [11:0] oth, logic id);
        if (s == 1) return id;
        if (s == 17) return ~id;
        if (s >= 2 && s <= 13) return own[13 - s];
        if (s >= 18 && s <= 29) return oth[29 - s];
        return 1'b0;
    endfunction : slot_bit

    // coding follows the config latched at the previous select fall
    task automatic run(input int n, input logic [11:0] a, input logic [11:0] b,
                       input logic tst, input logic chk);
        logic tw;
        logic [11:0] ca, cb;
        int s0;
        tw = cur.wide_range | (~cur.single_ended & ~cur.channel[0]);
        ca = tw ? a ^ 12'h800 : a;
        cb = tw ? b ^ 12'h800 : b;
        s0 = strobes;
        @(posedge clock);
        res_a <= tst ? ~a : a;
        res_b <= tst ? ~b : b;
        i_host.frame(n);
        cur = pins;
        `CHK("strobe", s0 + 1, strobes)
        `CHK("mux_cfg", pins, mux_cfg)
        `CHK("oe_off", 2'b00, {oe_a, oe_b})
        if (chk) begin
            for (int s = 0; s <= n && s < 32; s++) begin
                `CHK("line_a", slot_bit(s, ca, cb, 1'b0), i_host.da[s])
                `CHK("line_b", slot_bit(s, cb, ca, 1'b1), i_host.db[s])
                `CHK("drive", 2'b11, {i_host.ea[s], i_host.eb[s]})
            end
            if (n == 32) `CHK("rel32", 2'b00, {i_host.ea[32], i_host.eb[32]})
            if (n > 14) `CHK("track", 2'b10, {i_host.th[12], i_host.th[14]})
        end
    endtask : run

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial begin
        repeat (30000) @(posedge clock);
        error_cnt++;
        stop_test();
    end

    initial begin
        {reset, bus_wr, bus_rd, bus_addr, bus_wdata, res_a, res_b} = '0;
        reset = 1'b1;
        pins = 5'h10;
        cur = '0;
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        `CHK("mode", PWR_NORMAL, pmode)
        bus_write(8'h04, 32'h0000_0ABC);
        bus_read(8'h04, rd);
        `CHK("test_rw", 32'h0000_0ABC, rd)
        bus_read(8'h24, rd);
        `CHK("unmapped", 32'h0000_0000, rd)
        run(32, 12'h5A3, 12'h1C7, 1'b0, 1'b1);
        pins <= 5'h02;
        run(16, 12'hFFF, 12'h001, 1'b0, 1'b1);
        pins <= 5'h1B;
        run(14, 12'h800, 12'h7FF, 1'b0, 1'b1);
        bus_write(8'h00, 32'h0000_0001);
        bus_write(8'h04, 32'h0000_03C5);
        bus_write(8'h08, 32'h0000_0A5A);
        run(32, 12'h3C5, 12'hA5A, 1'b1, 1'b1);
        bus_write(8'h00, 32'h0000_0000);
        i_host.half = 8;
        i_host.rise_smp = 1'b1;
        run(16, 12'h123, 12'h456, 1'b0, 1'b1);
        i_host.rise_smp = 1'b0;
        i_host.half = 4;
        run(1, 12'h000, 12'h000, 1'b0, 1'b0);
        `CHK("glitch", PWR_NORMAL, pmode)
        run(12, 12'h000, 12'h000, 1'b0, 1'b0);
        `CHK("abort", PWR_NORMAL, pmode)
        run(5, 12'h000, 12'h000, 1'b0, 1'b0);
        `CHK("partial", PWR_PARTIAL, pmode)
        `CHK("pwr_off", 2'b00, {apwr, fpwr})
        run(1, 12'h000, 12'h000, 1'b0, 1'b0);
        `CHK("stay_part", PWR_PARTIAL, pmode)
        run(5, 12'h000, 12'h000, 1'b0, 1'b0);
        `CHK("full", PWR_FULL, pmode)
        bus_read(8'h0C, rd);
        `CHK("status", 2'h2, rd[1:0])
        run(1, 12'h000, 12'h000, 1'b0, 1'b0);
        `CHK("stay_full", PWR_FULL, pmode)
        run(12, 12'h000, 12'h000, 1'b0, 1'b0);
        `CHK("wake", PWR_NORMAL, pmode)
        `CHK("powered", 1'b1, fpwr)
        bus_read(8'h0C, rd);
        `CHK("wake_inval", 1'b0, rd[10])
        run(14, 12'h0F0, 12'hF0F, 1'b0, 1'b1);
        bus_read(8'h0C, rd);
        `CHK("valid", 1'b1, rd[10])
        bus_read(8'h10, rd);
        `CHK("last_a", 32'h0000_08F0, rd)
        stop_test();
    end
endmodule : dasp_top_tb_top
